// [common/crssc_consts.svh]
// Offsets, scope masks, field positions, reset values and timing counts of the reset scope controller.
`ifndef CRSSC_CONSTS_SVH
`define CRSSC_CONSTS_SVH

`define CRSSC_CLK_HZ 10000000
`define CRSSC_KEY_HOLD_S 10
`define CRSSC_RESET_PULSE_CYCLES 16

`define CRSSC_OFS_CTRL 8'h00
`define CRSSC_OFS_CAUSE 8'h04
`define CRSSC_OFS_CAUSE_CLEAR 8'h08
`define CRSSC_OFS_HP_MOD_RESET 8'h0c
`define CRSSC_OFS_LP_MOD_RESET 8'h10
`define CRSSC_OFS_STATUS 8'h14

`define CRSSC_CTRL_REBOOT 0
`define CRSSC_CTRL_HP_WIDEN 1
`define CRSSC_CTRL_LP_WIDEN 2
`define CRSSC_CTRL_RESET 3'h0

`define CRSSC_CAUSE_KEY 0
`define CRSSC_CAUSE_LOWBAT 1
`define CRSSC_CAUSE_INDEPENDENT_WATCHDOG 2
`define CRSSC_CAUSE_HP_WDT 3
`define CRSSC_CAUSE_LP_WDT 4
`define CRSSC_CAUSE_RESET 5'h00

`define CRSSC_RG_HP_CPU 0
`define CRSSC_RG_HP_SRAM_RET 1
`define CRSSC_RG_HP_SRAM_NORET 2
`define CRSSC_RG_HP_PERIPH 3
`define CRSSC_RG_HP_AON 4
`define CRSSC_RG_LP_CPU 5
`define CRSSC_RG_LP_SRAM_RET 6
`define CRSSC_RG_LP_SRAM_NORET 7
`define CRSSC_RG_LP_PERIPH 8
`define CRSSC_RG_LP_AON 9
`define CRSSC_RG_POWER_MANAGEMENT_CONTROLLER 10
`define CRSSC_RG_RTC 11
`define CRSSC_RG_INDEPENDENT_WATCHDOG 12

`define CRSSC_SCOPE_ALL 13'h1fff
`define CRSSC_SCOPE_KEEP_RTC_INDEPENDENT_WATCHDOG 13'h07ff
`define CRSSC_SCOPE_KEEP_AON_CORE 13'h03ff
`define CRSSC_SCOPE_HP_WDT 13'h0009
`define CRSSC_SCOPE_LP_WDT 13'h0120
`define CRSSC_SCOPE_HP_SYSRST 13'h0009
`define CRSSC_SCOPE_LP_SYSRST 13'h0120
`define CRSSC_SCOPE_HP_STANDBY 13'h000d
`define CRSSC_SCOPE_LP_STANDBY 13'h01a0

`define CRSSC_RESP_OKAY 2'h0
`define CRSSC_RESP_DECERR 2'h3

`endif

// [common/crssc_pkg.sv]
// Types shared by the reset scope controller.
package crssc_pkg;
    typedef logic [12:0] crssc_scope_t;
    typedef enum logic [3:0] {
        CRSSC_SRC_KEY = 4'b0000,
        CRSSC_SRC_SUPPLY_DROP = 4'b0001,
        CRSSC_SRC_LOW_BAT = 4'b0010,
        CRSSC_SRC_INDEPENDENT_WATCHDOG = 4'b0011,
        CRSSC_SRC_HP_WDT = 4'b0100,
        CRSSC_SRC_LP_WDT = 4'b0101,
        CRSSC_SRC_HP_SYSREQ = 4'b0110,
        CRSSC_SRC_LP_SYSREQ = 4'b0111,
        CRSSC_SRC_HIB_WAKE = 4'b1000,
        CRSSC_SRC_HP_STBY_WAKE = 4'b1001,
        CRSSC_SRC_LP_STBY_WAKE = 4'b1010,
        CRSSC_SRC_INDEPENDENT_WATCHDOG_CLR = 4'b1011
    } crssc_src_t;
endpackage : crssc_pkg

// [hw/crssc_top.sv]
// Reset source collector and scoped reset driver with cause flags and an AXI4-Lite register port.
//
// Functional notes
// - Power-up asserts a reset over every region including the always-on domain.
// - A system supply drop asserts a reset over every region.
// - Power key held high over ten seconds resets all but clock and independent watchdog.
// - Key hold reset sets a sticky cause flag; its clear control clears it.
// - Low battery resets all but clock and watchdog; sets sticky flag, clear control clears.
// - Independent watchdog timeout resets all but clock and watchdog; flag cleared by watchdog.
// - HP watchdog timeout by default resets only the HP processor and HP peripherals.
// - HP widen enable set: HP watchdog resets all but controller, clock, watchdog; sets flag.
// - LP watchdog timeout by default resets LP processor and peripherals, not LP always-on.
// - LP widen enable set: LP watchdog resets all but controller, clock, watchdog; sets flag.
// - Writing 1 to the reboot bit resets all but controller, clock and watchdog.
// - Reboot bit reads 1 afterwards; it must be written 0 before rebooting again.
// - HP processor or debugger system reset request resets only the HP processor and HP peripherals.
// - LP processor or debugger system reset request resets only the LP processor and LP peripherals.
// - Per-module reset bits let software reset a single module alone.
// - Hibernate wake-up resets all but controller, clock and independent watchdog.
// - HP standby wake-up resets the HP processor, non-retention memory and peripherals only.
// - LP standby wake-up resets the LP processor, non-retention memory and peripherals only.
`timescale 1ns/1ns
`include "crssc_consts.svh"

module crssc_top
    import crssc_pkg::*;
#(
    parameter int unsigned KEY_HOLD_CYCLES = `CRSSC_KEY_HOLD_S * `CRSSC_CLK_HZ,
    parameter int unsigned KEY_CNT_W = 27,
    parameter int unsigned MOD_W = 32,
    parameter int unsigned ADDR_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic power_key_input,
    input wire logic system_supply_drop,
    input wire logic low_battery,
    input wire logic indep_watchdog_timeout,
    input wire logic indep_watchdog_irq_clear,
    input wire logic hp_watchdog_timeout,
    input wire logic lp_watchdog_timeout,
    input wire logic hp_core_system_reset_request,
    input wire logic lp_core_system_reset_request,
    input wire logic hibernate_wake,
    input wire logic hp_standby_wake,
    input wire logic lp_standby_wake,
    output logic [12:0] region_reset,
    output logic [MOD_W-1:0] hp_module_reset,
    output logic [MOD_W-1:0] lp_module_reset,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int unsigned NSRC = 12;
    localparam logic [KEY_CNT_W-1:0] KEY_LIMIT = KEY_CNT_W'(KEY_HOLD_CYCLES);
    localparam logic [4:0] PULSE = 5'(`CRSSC_RESET_PULSE_CYCLES);

    logic [NSRC-1:0] ext_in;
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic [NSRC-1:0] sync3;
    logic [NSRC-1:0] rise;
    logic [KEY_CNT_W-1:0] key_cnt;
    logic key_fired;
    logic key_evt;
    logic [2:0] ctrl;
    logic [4:0] cause;
    logic reboot_fire;
    logic [4:0] pulse_cnt;
    crssc_scope_t next_scope;
    logic wr_fire;
    logic rd_fire;
    logic [ADDR_W-3:0] wr_idx;
    logic [ADDR_W-3:0] rd_idx;
    logic [4:0] cause_set;
    logic [4:0] cause_clr;

    assign ext_in = {indep_watchdog_irq_clear, lp_standby_wake, hp_standby_wake, hibernate_wake,
                     lp_core_system_reset_request, hp_core_system_reset_request, lp_watchdog_timeout,
                     hp_watchdog_timeout, indep_watchdog_timeout, low_battery, system_supply_drop,
                     power_key_input};

    // Every source may come from another domain, so all pass two flops; edges compare the second stage with a third flop.
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= ext_in[gi];
                    sync2[gi] <= sync1[gi];
                    sync3[gi] <= sync2[gi];
                end
            end
            assign rise[gi] = sync2[gi] & ~sync3[gi];
        end
    endgenerate

    // The key must be released before a second hold can fire, so a stuck key gives one reset only.
    always_ff @(posedge ref_clk) begin
        if (rst || !sync2[CRSSC_SRC_KEY]) begin
            key_cnt <= '0;
            key_fired <= 1'b0;
            key_evt <= 1'b0;
        end else if (!key_fired && key_cnt == KEY_LIMIT) begin
            key_fired <= 1'b1;
            key_evt <= 1'b1;
        end else begin
            key_evt <= 1'b0;
            if (!key_fired) begin
                key_cnt <= key_cnt + 1'b1;
            end
        end
    end

    assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
    assign rd_fire = s_axi_arready & s_axi_arvalid;
    assign wr_idx = s_axi_awaddr[ADDR_W-1:2];
    assign rd_idx = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        next_scope = '0;
        if (rise[CRSSC_SRC_SUPPLY_DROP]) begin
            next_scope = next_scope | `CRSSC_SCOPE_ALL;
        end
        if (key_evt || rise[CRSSC_SRC_LOW_BAT] || rise[CRSSC_SRC_INDEPENDENT_WATCHDOG]) begin
            next_scope = next_scope | `CRSSC_SCOPE_KEEP_RTC_INDEPENDENT_WATCHDOG;
        end
        if (rise[CRSSC_SRC_HP_WDT]) begin
            next_scope = next_scope | (ctrl[`CRSSC_CTRL_HP_WIDEN] ? `CRSSC_SCOPE_KEEP_AON_CORE
                                                                  : `CRSSC_SCOPE_HP_WDT);
        end
        if (rise[CRSSC_SRC_LP_WDT]) begin
            next_scope = next_scope | (ctrl[`CRSSC_CTRL_LP_WIDEN] ? `CRSSC_SCOPE_KEEP_AON_CORE
                                                                  : `CRSSC_SCOPE_LP_WDT);
        end
        if (reboot_fire || rise[CRSSC_SRC_HIB_WAKE]) begin
            next_scope = next_scope | `CRSSC_SCOPE_KEEP_AON_CORE;
        end
        if (rise[CRSSC_SRC_HP_SYSREQ]) begin
            next_scope = next_scope | `CRSSC_SCOPE_HP_SYSRST;
        end
        if (rise[CRSSC_SRC_LP_SYSREQ]) begin
            next_scope = next_scope | `CRSSC_SCOPE_LP_SYSRST;
        end
        if (rise[CRSSC_SRC_HP_STBY_WAKE]) begin
            next_scope = next_scope | `CRSSC_SCOPE_HP_STANDBY;
        end
        if (rise[CRSSC_SRC_LP_STBY_WAKE]) begin
            next_scope = next_scope | `CRSSC_SCOPE_LP_STANDBY;
        end
    end

    // A new event during a pulse merges its scope and restarts the pulse, so no region is cut short.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            region_reset <= `CRSSC_SCOPE_ALL;
            pulse_cnt <= PULSE;
        end else if (next_scope != '0) begin
            region_reset <= (pulse_cnt != '0 ? region_reset : '0) | next_scope;
            pulse_cnt <= PULSE;
        end else if (pulse_cnt != '0) begin
            pulse_cnt <= pulse_cnt - 1'b1;
            if (pulse_cnt == 5'h01) begin
                region_reset <= '0;
            end
        end
    end

    // Control bits live in the power controller and fall back to defaults whenever its region is reset.
    always_ff @(posedge ref_clk) begin
        reboot_fire <= 1'b0;
        if (rst || next_scope[`CRSSC_RG_POWER_MANAGEMENT_CONTROLLER]) begin
            ctrl <= `CRSSC_CTRL_RESET;
        end else if (wr_fire && wr_idx == `CRSSC_OFS_CTRL >> 2 && s_axi_wstrb[0]) begin
            ctrl <= s_axi_wdata[2:0];
            reboot_fire <= s_axi_wdata[`CRSSC_CTRL_REBOOT] & ~ctrl[`CRSSC_CTRL_REBOOT];
        end
    end

    always_comb begin
        cause_set = '0;
        cause_set[`CRSSC_CAUSE_KEY] = key_evt;
        cause_set[`CRSSC_CAUSE_LOWBAT] = rise[CRSSC_SRC_LOW_BAT];
        cause_set[`CRSSC_CAUSE_INDEPENDENT_WATCHDOG] = rise[CRSSC_SRC_INDEPENDENT_WATCHDOG];
        cause_set[`CRSSC_CAUSE_HP_WDT] = rise[CRSSC_SRC_HP_WDT] & ctrl[`CRSSC_CTRL_HP_WIDEN];
        cause_set[`CRSSC_CAUSE_LP_WDT] = rise[CRSSC_SRC_LP_WDT] & ctrl[`CRSSC_CTRL_LP_WIDEN];
        cause_clr = '0;
        if (wr_fire && wr_idx == `CRSSC_OFS_CAUSE_CLEAR >> 2 && s_axi_wstrb[0]) begin
            cause_clr = s_axi_wdata[4:0] & 5'h1b;
        end
        cause_clr[`CRSSC_CAUSE_INDEPENDENT_WATCHDOG] = rise[CRSSC_SRC_INDEPENDENT_WATCHDOG_CLR];
    end

    // Only a full supply reset wipes the flags; set wins over a clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (rst || rise[CRSSC_SRC_SUPPLY_DROP]) begin
            cause <= `CRSSC_CAUSE_RESET;
        end else begin
            cause <= (cause & ~cause_clr) | cause_set;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || region_reset[`CRSSC_RG_HP_PERIPH]) begin
            hp_module_reset <= '0;
        end else if (wr_fire && wr_idx == `CRSSC_OFS_HP_MOD_RESET >> 2) begin
            for (int b = 0; b < MOD_W / 8; b++) begin
                if (s_axi_wstrb[b]) begin
                    hp_module_reset[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst || region_reset[`CRSSC_RG_LP_PERIPH]) begin
            lp_module_reset <= '0;
        end else if (wr_fire && wr_idx == `CRSSC_OFS_LP_MOD_RESET >> 2) begin
            for (int b = 0; b < MOD_W / 8; b++) begin
                if (s_axi_wstrb[b]) begin
                    lp_module_reset[b*8 +: 8] <= s_axi_wdata[b*8 +: 8];
                end
            end
        end
    end

    // Address and data are taken together, one cycle after both are offered.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CRSSC_RESP_OKAY;
        end else begin
            s_axi_awready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            s_axi_wready <= s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx <= `CRSSC_OFS_STATUS >> 2) ? `CRSSC_RESP_OKAY : `CRSSC_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRSSC_RESP_OKAY;
        end else begin
            s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `CRSSC_RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                if (rd_idx == `CRSSC_OFS_CTRL >> 2) begin
                    s_axi_rdata[2:0] <= ctrl;
                end else if (rd_idx == `CRSSC_OFS_CAUSE >> 2) begin
                    s_axi_rdata[4:0] <= cause;
                end else if (rd_idx == `CRSSC_OFS_HP_MOD_RESET >> 2) begin
                    s_axi_rdata[MOD_W-1:0] <= hp_module_reset;
                end else if (rd_idx == `CRSSC_OFS_LP_MOD_RESET >> 2) begin
                    s_axi_rdata[MOD_W-1:0] <= lp_module_reset;
                end else if (rd_idx == `CRSSC_OFS_STATUS >> 2) begin
                    s_axi_rdata[12:0] <= region_reset;
                end else if (rd_idx != `CRSSC_OFS_CAUSE_CLEAR >> 2) begin
                    s_axi_rresp <= `CRSSC_RESP_DECERR;
                end
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_por_whole_chip: assert property ($fell(rst) |-> region_reset == `CRSSC_SCOPE_ALL)
        else $error("Region resets not all asserted after power-up.");
    a_drop_whole_chip: assert property (rise[CRSSC_SRC_SUPPLY_DROP] |=> region_reset == `CRSSC_SCOPE_ALL)
        else $error("Supply drop did not reset every region.");
    a_key_hold_spares: assert property (key_evt && pulse_cnt == '0 && next_scope == `CRSSC_SCOPE_KEEP_RTC_INDEPENDENT_WATCHDOG
        |=> region_reset == `CRSSC_SCOPE_KEEP_RTC_INDEPENDENT_WATCHDOG)
        else $error("Key hold reset scope wrong.");
    a_key_hold_time: assert property ($rose(key_evt) |-> $past(key_cnt) == KEY_LIMIT && sync3[CRSSC_SRC_KEY])
        else $error("Key hold fired before the hold time.");
    a_key_flag_set: assert property (key_evt && !rise[CRSSC_SRC_SUPPLY_DROP] |=> cause[`CRSSC_CAUSE_KEY])
        else $error("Key hold cause flag not set.");
    a_lowbat_flag_set: assert property (rise[CRSSC_SRC_LOW_BAT] && !rise[CRSSC_SRC_SUPPLY_DROP]
        |=> cause[`CRSSC_CAUSE_LOWBAT] && region_reset[`CRSSC_RG_POWER_MANAGEMENT_CONTROLLER])
        else $error("Low battery flag or reset missing.");
    a_independent_watchdog_flag_set: assert property (rise[CRSSC_SRC_INDEPENDENT_WATCHDOG] && !rise[CRSSC_SRC_SUPPLY_DROP]
        |=> cause[`CRSSC_CAUSE_INDEPENDENT_WATCHDOG] && !region_reset[`CRSSC_RG_INDEPENDENT_WATCHDOG] || $past(pulse_cnt) != '0)
        else $error("Independent watchdog event handled wrongly.");
    a_hp_narrow_scope: assert property (next_scope == `CRSSC_SCOPE_HP_WDT && pulse_cnt == '0
        && !ctrl[`CRSSC_CTRL_HP_WIDEN] |=> region_reset == `CRSSC_SCOPE_HP_WDT
        && !cause[`CRSSC_CAUSE_HP_WDT] || $past(cause[`CRSSC_CAUSE_HP_WDT]))
        else $error("Default HP watchdog scope wrong.");
    a_hp_widen_flag: assert property (rise[CRSSC_SRC_HP_WDT] && ctrl[`CRSSC_CTRL_HP_WIDEN]
        && !rise[CRSSC_SRC_SUPPLY_DROP] |=> cause[`CRSSC_CAUSE_HP_WDT]
        && region_reset[`CRSSC_RG_LP_AON] && !region_reset[`CRSSC_RG_POWER_MANAGEMENT_CONTROLLER] || $past(pulse_cnt) != '0)
        else $error("Widened HP watchdog reset wrong.");
    a_lp_widen_flag: assert property (rise[CRSSC_SRC_LP_WDT] && ctrl[`CRSSC_CTRL_LP_WIDEN]
        && !rise[CRSSC_SRC_SUPPLY_DROP] |=> cause[`CRSSC_CAUSE_LP_WDT] && region_reset[`CRSSC_RG_HP_AON])
        else $error("Widened LP watchdog reset wrong.");
    a_reboot_edge_only: assert property (reboot_fire |-> $past(ctrl[`CRSSC_CTRL_REBOOT]) == 1'b0
        ##1 region_reset[`CRSSC_RG_LP_AON])
        else $error("Reboot fired without a fresh write of one.");
    a_reboot_bit_holds: assert property (reboot_fire && !next_scope[`CRSSC_RG_POWER_MANAGEMENT_CONTROLLER]
        |-> ctrl[`CRSSC_CTRL_REBOOT] ##1 ctrl[`CRSSC_CTRL_REBOOT] || next_scope[`CRSSC_RG_POWER_MANAGEMENT_CONTROLLER])
        else $error("Reboot bit did not stay one.");
    a_standby_keeps_ret: assert property (next_scope == `CRSSC_SCOPE_HP_STANDBY && pulse_cnt == '0
        |=> !region_reset[`CRSSC_RG_HP_SRAM_RET] && region_reset[`CRSSC_RG_HP_SRAM_NORET])
        else $error("HP standby wake touched retention memory.");
    a_lp_sysreq_scope: assert property (next_scope == `CRSSC_SCOPE_LP_SYSRST && pulse_cnt == '0
        |=> region_reset == `CRSSC_SCOPE_LP_SYSRST)
        else $error("LP system reset scope wrong.");
    a_flags_stable: assert property (cause_set == '0 && cause_clr == '0 && !rise[CRSSC_SRC_SUPPLY_DROP]
        |=> $stable(cause))
        else $error("Cause flags changed with no set or clear.");
    a_pulse_held: assert property ($rose(region_reset != '0) |-> (region_reset != '0) [*8])
        else $error("Region reset pulse too short.");
    a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("Write response dropped before it was taken.");
    a_key_fires_once: assert property (key_evt |=> !key_evt)
        else $error("Key hold fired twice in a row.");
    a_lp_standby_scope: assert property (next_scope == `CRSSC_SCOPE_LP_STANDBY
        && pulse_cnt == '0 |=> region_reset == `CRSSC_SCOPE_LP_STANDBY)
        else $error("LP standby wake scope wrong.");
    a_hib_wake_scope: assert property (rise[CRSSC_SRC_HIB_WAKE]
        && next_scope == `CRSSC_SCOPE_KEEP_AON_CORE && pulse_cnt == '0 |=> region_reset == `CRSSC_SCOPE_KEEP_AON_CORE)
        else $error("Hibernate wake scope wrong.");
    a_reboot_scope: assert property (reboot_fire
        && next_scope == `CRSSC_SCOPE_KEEP_AON_CORE && pulse_cnt == '0 |=> region_reset == `CRSSC_SCOPE_KEEP_AON_CORE)
        else $error("Reboot scope wrong.");
    a_pulse_ends: assert property (pulse_cnt == 5'h01 && next_scope == '0
        |=> region_reset == '0 && pulse_cnt == '0)
        else $error("Region reset pulse did not end.");
    a_hp_mod_cleared: assert property (region_reset[`CRSSC_RG_HP_PERIPH] |=> hp_module_reset == '0)
        else $error("HP module resets kept during subsystem reset.");
    a_lp_mod_cleared: assert property (region_reset[`CRSSC_RG_LP_PERIPH] |=> lp_module_reset == '0)
        else $error("LP module resets kept during subsystem reset.");

    c_key_reset: cover property (key_evt ##1 cause[`CRSSC_CAUSE_KEY]);
    c_reboot: cover property (reboot_fire ##1 region_reset == `CRSSC_SCOPE_KEEP_AON_CORE);
    c_hp_widened: cover property (rise[CRSSC_SRC_HP_WDT] && ctrl[`CRSSC_CTRL_HP_WIDEN]);
    c_lp_standby: cover property (rise[CRSSC_SRC_LP_STBY_WAKE] ##1 region_reset[`CRSSC_RG_LP_SRAM_NORET]);
    c_supply_drop: cover property (rise[CRSSC_SRC_SUPPLY_DROP] ##1 region_reset == `CRSSC_SCOPE_ALL);

endmodule : crssc_top

// [tb/crssc_far_model.sv]
// Far-side model of the watchdogs, processors, power monitors and power key.
`timescale 1ns/1ns
module crssc_far_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic [3:0] sel,
    input wire logic [7:0] len,
    output logic [11:0] lines
);
    logic [7:0] left;
    logic [3:0] cur;
    // One source line at a time is held high for len cycles, so levels never overlap by accident.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            left <= 8'h00;
            cur <= 4'h0;
        end else if (start) begin
            left <= len;
            cur <= sel;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign lines = (left != 8'h00) ? (12'h001 << cur) : 12'h000;
endmodule : crssc_far_model

// [tb/tb_crssc_top.sv]
// Self-checking bench for the reset scope controller.
`timescale 1ns/1ns
module tb_crssc_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] len = 8'h00;
    logic [11:0] lines;
    logic [12:0] region_reset;
    logic [31:0] hp_module_reset;
    logic [31:0] lp_module_reset;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_bresp;
    logic [1:0] s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] cause = 32'h0000_0000, ctrl = 32'h0000_0000, hpm = 32'h0000_0000, lpm = 32'h0000_0000;
    logic [31:0] rnd = 32'd82780;
    logic [31:0] rd;
    logic [1:0] rsp;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;

    crssc_far_model i_crssc_far_model (.ref_clk(ref_clk), .rst(rst), .start(start), .sel(sel), .len(len),
        .lines(lines));
    crssc_top #(.KEY_HOLD_CYCLES(20)) i_crssc_top (.ref_clk(ref_clk), .rst(rst), .power_key_input(lines[0]),
        .system_supply_drop(lines[1]), .low_battery(lines[2]), .indep_watchdog_timeout(lines[3]),
        .hp_watchdog_timeout(lines[4]), .lp_watchdog_timeout(lines[5]), .hp_core_system_reset_request(lines[6]),
        .lp_core_system_reset_request(lines[7]), .hibernate_wake(lines[8]), .hp_standby_wake(lines[9]),
        .lp_standby_wake(lines[10]), .indep_watchdog_irq_clear(lines[11]), .region_reset(region_reset),
        .hp_module_reset(hp_module_reset), .lp_module_reset(lp_module_reset), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    always #50 ref_clk = ~ref_clk;

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge ref_clk);
        chk(32'(rsp), (a <= 8'h14) ? 32'h0000_0000 : 32'h0000_0003);
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge ref_clk);
        chk(rd, exp);
    endtask : rchk

    task automatic fire(input logic [3:0] s, input logic [7:0] l);
        logic [12:0] e;
        case (s)
            4'h0: begin e = 13'h07ff; cause[0] = 1'b1; end
            4'h1: begin e = 13'h1fff; cause = 32'h0000_0000; end
            4'h2: begin e = 13'h07ff; cause[1] = 1'b1; end
            4'h3: begin e = 13'h07ff; cause[2] = 1'b1; end
            4'h4: begin e = ctrl[1] ? 13'h03ff : 13'h0009; cause[3] = cause[3] | ctrl[1]; end
            4'h5: begin e = ctrl[2] ? 13'h03ff : 13'h0120; cause[4] = cause[4] | ctrl[2]; end
            4'h6: e = 13'h0009;
            4'h7: e = 13'h0120;
            4'h8: e = 13'h03ff;
            4'h9: e = 13'h000d;
            4'ha: e = 13'h01a0;
            default: begin e = 13'h0000; cause[2] = 1'b0; end
        endcase
        if (e[10]) ctrl = 32'h0000_0000;
        if (e[3]) hpm = 32'h0000_0000;
        if (e[8]) lpm = 32'h0000_0000;
        start <= 1'b1;
        sel <= s;
        len <= l;
        @(posedge ref_clk);
        start <= 1'b0;
        repeat (l + 5) @(posedge ref_clk);
        chk(32'(region_reset), 32'(e));
        repeat (30) @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_0000);
        chk(hp_module_reset, hpm);
        chk(lp_module_reset, lpm);
        rchk(8'h04, cause);
        rchk(8'h00, ctrl);
    endtask : fire

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_1fff);
        repeat (20) @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_0000);
        rchk(8'h20, 32'h0000_0000);
        chk(32'(rsp), 32'h0000_0003);
        wr(8'h20, 32'h0000_0001);
        $display("Test reset and bus done");
        for (int i = 0; i < 12; i++) fire(4'(i), (i == 0) ? 8'h1e : 8'h02);
        wr(8'h00, 32'h0000_0006);
        ctrl = 32'h0000_0006;
        fire(4'h4, 8'h02);
        fire(4'h5, 8'h02);
        wr(8'h08, 32'h0000_001b);
        cause = cause & 32'h0000_0004;
        rchk(8'h04, cause);
        $display("Test events and flags done");
        wr(8'h00, 32'h0000_0007);
        ctrl = 32'h0000_0007;
        repeat (2) @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_03ff);
        rchk(8'h14, 32'h0000_03ff);
        repeat (30) @(posedge ref_clk);
        rchk(8'h00, ctrl);
        wr(8'h00, 32'h0000_0007);
        repeat (3) @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_0000);
        wr(8'h00, 32'h0000_0006);
        wr(8'h00, 32'h0000_0007);
        repeat (2) @(posedge ref_clk);
        chk(32'(region_reset), 32'h0000_03ff);
        repeat (30) @(posedge ref_clk);
        $display("Test reboot done");
        rnd = xs(rnd);
        hpm = rnd;
        wr(8'h0c, hpm);
        rnd = xs(rnd);
        lpm = rnd;
        wr(8'h10, lpm);
        rchk(8'h0c, hpm);
        rchk(8'h10, lpm);
        chk(hp_module_reset, hpm);
        fire(4'h9, 8'h02);
        $display("Test module resets done");
        stop_test();
    end
endmodule : tb_crssc_top
